// ===== verif/sfl_ctrl_chk.sv
// Checker of the synthesizer control block, on its ports only.
// Assumes one hclk domain and the active-low asynchronous hresetn.
`timescale 1ns/1ns

module sfl_ctrl_chk
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pin and core control
   input wire logic chip_enable,
   input wire logic pump_output_oe,
   input wire logic counter_reset,
   input wire logic power_down,
   input wire logic internal_reset,
   input wire logic [23:0] ref_word,
   input wire logic [23:0] ab_word
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   AST_PULSE_ONE_CYCLE:
      assert property (internal_reset |=> !internal_reset)
      else $error("internal reset longer than one cycle");
   AST_PULSE_HOLDS_COUNTERS:
      assert property (internal_reset |-> ##[0:1] counter_reset)
      else $error("reset pulse did not reach counters");
   AST_PULSE_FLOATS_PUMP:
      assert property (internal_reset |-> ##[0:1] !pump_output_oe)
      else $error("reset pulse left pump driven");
   AST_ENABLE_LOW_DOWN:
      assert property ($fell(chip_enable) |-> ##[1:4] power_down)
      else $error("enable pin low did not power down");
   AST_ENABLE_HIGH_UP:
      assert property ($rose(chip_enable) |-> ##[1:5] !power_down)
      else $error("enable pin high did not power up");
   AST_DOWN_HOLDS_COUNTERS:
      assert property (power_down |-> ##[0:1] counter_reset)
      else $error("power down left counters running");
   AST_DOWN_FLOATS_PUMP:
      assert property (power_down [*2] |-> !pump_output_oe)
      else $error("power down left pump driven");
   AST_LATCHES_KEPT:
      assert property ($changed(chip_enable) |=>
                       $stable(ref_word) && $stable(ab_word))
      else $error("latch changed on enable pin toggle");

   COV_PULSE: cover property (internal_reset);
   COV_BOOST_CLEARED: cover property ($fell(ab_word[21]));
   COV_DOWN: cover property ($rose(power_down));
endmodule

bind sfl_ctrl sfl_ctrl_chk u_sfl_ctrl_chk (.hclk, .hresetn, .chip_enable,
   .pump_output_oe, .counter_reset, .power_down, .internal_reset,
   .ref_word, .ab_word);

// ===== verif/sfl_host_model.sv
// Host model: drives the 3-wire serial write port of the control block.
// Assumes the bench calls send() and waits for it to return.
`timescale 1ns/1ns

module sfl_host_model
(
   // Serial write port
   output logic ser_clk,
   output logic ser_data,
   output logic latch_strobe
);
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_strobe = 1'b0;
   end

   // ------------------------------------------------------------------
   // Word transfer, DB23 first, 800 ns serial clock period
   // ------------------------------------------------------------------
   // The clock stands low between words, and the data line shows the
   // inverse of the last bit so a stale value cannot pass for a match.
   task automatic send(input logic [23:0] word);
      for (int i = 23; i >= 0; i--)
      begin
         ser_data = word[i];
         #200;
         ser_clk = 1'b1;
         #400;
         ser_clk = 1'b0;
         #200;
      end
      ser_data = ~word[0];
      latch_strobe = 1'b1;
      #800;
      latch_strobe = 1'b0;
      #800;
   endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench of the synthesizer control block.
// Assumes sfl_pkg, sfl_ctrl, the host model and the checker are compiled.
`timescale 1ns/1ns

module tb_top;
   logic hclk, hresetn, hsel, hwrite, hready, chip_enable, pd_cycle;
   logic hreadyout, hresp, pump_output_oe, pd_polarity, counter_reset;
   logic power_down, internal_reset, monitor_output_pin;
   logic ser_clk, ser_data, latch_strobe;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, divider_ratio;
   logic [2:0] hsize, pump_current;
   logic [23:0] ref_word, ab_word, r;
   int fail_count, checked, pulses, p0;
   sfl_pkg::sfl_func_type f;
   sfl_pkg::sfl_ab_type ab;

   assign hready = hreadyout;

   sfl_ctrl u_sfl_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ser_clk,
      .ser_data, .latch_strobe, .chip_enable, .pd_cycle, .pump_current,
      .pump_output_oe, .pd_polarity, .divider_ratio, .counter_reset,
      .power_down, .internal_reset, .ref_word, .ab_word,
      .monitor_output_pin);
   sfl_host_model u_sfl_host_model (.ser_clk, .ser_data, .latch_strobe);

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk)
      if (internal_reset === 1'b1)
         pulses++;

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s: %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         chk(0, 1, "bus hang");
         end_of_test();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= 32'(a);
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk(hresp, 0, "bus response");
   endtask

   // Bus load: latch takes it at the data edge, outputs one edge later.
   task automatic ld(input logic [23:0] w);
      bus(1'b1, sfl_pkg::ADDR_LOAD, 32'(w));
      repeat (2) @(posedge hclk);
      #1;
   endtask

   // Serial load: three edges of sampling, one of output register.
   task automatic sh(input logic [23:0] w);
      u_sfl_host_model.send(w);
      repeat (5) @(posedge hclk);
      #1;
   endtask

   task automatic pd(input int n);
      repeat (n)
      begin
         @(posedge hclk);
         pd_cycle <= 1'b1;
         repeat (4) @(posedge hclk);
         pd_cycle <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      #1;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_init();
      f = '0;
      f.pd_polarity = 1'b1;
      f.monitor_sel = 3'd7;
      f.latch_select = sfl_pkg::SEL_INIT;
      p0 = pulses;
      sh(f);
      chk(pulses - p0, 1, "init pulse");
      bus(1'b0, sfl_pkg::ADDR_FUNC, 0);
      chk(rd[23:2], 32'(f[23:2]), "init fields");
      chk(pd_polarity, 1, "polarity");
      chk(monitor_output_pin, 1, "monitor high");
      f.latch_select = sfl_pkg::SEL_FUNC;
      f.divider_ratio = 2'b01;
      sh(f);
      chk(divider_ratio, 1, "divider");
      sh(24'h00_0140);
      chk(ref_word, 24'h00_0140, "ref word");
      ab = '0;
      ab.b_count = 13'd20;
      ab.a_count = 6'd3;
      ab.latch_select = sfl_pkg::SEL_AB;
      sh(ab);
      chk(pulses - p0, 2, "first ab pulse");
      sh(ab);
      chk(pulses - p0, 2, "second ab no pulse");
      chk(ab_word, ab, "ab word");
      $display("test init done");
   endtask

   task automatic test_timed();
      f.fastlock_enable = 1'b1;
      f.fastlock_mode = 1'b1;
      f.pump_current_primary = 3'd1;
      f.pump_current_secondary = 3'd6;
      f.monitor_sel = 3'd1;
      ab.boost_request = 1'b1;
      for (int c = 0; c < 2; c++)
      begin
         f.timeout_code = 4'(c);
         ld(f);
         ld(ab);
         chk(pump_current, 6, "secondary");
         chk(monitor_output_pin, 1, "monitor fastlock");
         bus(1'b0, sfl_pkg::ADDR_STATUS, 0);
         chk(rd, 32'h0000_0003, "timer started");
         pd(3 + 4 * c);
         chk(ab_word[21], 1, "boost before expiry");
         bus(1'b0, sfl_pkg::ADDR_STATUS, 0);
         chk(rd, 32'((3 + 4 * c) * 256 + 3), "timer count");
         pd(1);
         chk(ab_word[21], 0, "boost cleared");
         chk(pump_current, 1, "primary back");
         chk(monitor_output_pin, 0, "monitor fastlock off");
      end
      $display("test timed done");
   endtask

   task automatic test_manual();
      f.fastlock_mode = 1'b0;
      ld(f);
      ld(ab);
      chk(pump_current, 6, "manual enter");
      pd(8);
      chk(ab_word[21], 1, "no timer in manual");
      ab.boost_request = 1'b0;
      ld(ab);
      chk(pump_current, 1, "manual exit");
      f.fastlock_enable = 1'b0;
      ld(f);
      ab.boost_request = 1'b1;
      ld(ab);
      chk(pump_current, 1, "fastlock disabled");
      $display("test manual done");
   endtask

   task automatic test_fields();
      f.pump_tristate = 1'b1;
      f.monitor_sel = 3'd0;
      ld(f);
      chk(pump_output_oe, 0, "pump floated");
      chk(monitor_output_pin, 0, "monitor low");
      f.pump_tristate = 1'b0;
      ld(f);
      chk(pump_output_oe, 1, "pump driven");
      f.counter_hold = 1'b1;
      ld(f);
      chk(counter_reset, 1, "hold");
      f.counter_hold = 1'b0;
      ld(f);
      chk(counter_reset, 0, "release");
      $display("test fields done");
   endtask

   task automatic test_enable();
      r = ref_word;
      @(posedge hclk);
      chip_enable <= 1'b0;
      repeat (6) @(posedge hclk);
      #1;
      chk(power_down, 1, "pin down");
      f.monitor_sel = 3'd7;
      ld(f);
      @(posedge hclk);
      chip_enable <= 1'b1;
      repeat (6) @(posedge hclk);
      #1;
      chk(power_down, 0, "pin up");
      chk(ref_word, r, "ref kept");
      chk(monitor_output_pin, 1, "load while down");
      $display("test enable done");
   endtask

   // Initialization word that programs synchronous power-down.
   task automatic test_power();
      p0 = pulses;
      f.monitor_sel = 3'd4;
      f.power_down_request = 1'b1;
      f.power_down_sync_select = 1'b1;
      f.latch_select = sfl_pkg::SEL_INIT;
      ld(f);
      chk(pulses - p0, 1, "second init pulse");
      chk(power_down, 1, "pulse starts sync power down");
      chk(monitor_output_pin, 1, "monitor power down");
      f.power_down_request = 1'b0;
      f.latch_select = sfl_pkg::SEL_FUNC;
      ld(f);
      chk(power_down, 0, "sync power down cleared");
      chk(monitor_output_pin, 0, "monitor powered up");
      $display("test power done");
   endtask

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      chip_enable = 1'b1;
      pd_cycle = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      #1;
      test_init();
      test_timed();
      test_manual();
      test_fields();
      test_power();
      test_enable();
      end_of_test();
   end

   initial
   begin
      repeat (90000) @(posedge hclk);
      chk(0, 1, "run timeout");
      end_of_test();
   end
endmodule

// ===== verilog/sfl_ctrl.sv
// Fastlock, initialization and power-down control of the synthesizer.
// Assumes serial pins and chip enable are asynchronous to hclk and slow
// against it (serial clock well below 5 MHz), and that the AHB-Lite
// master issues single whole-word transfers.
//
// Function
// [R01] Function latch bit 9 enables fastlock; no fastlock otherwise.
// [R02] Bit 10 picks variant: 0 manual exit, 1 timed exit.
// [R03] While fastlock active, pump uses the secondary current code.
// [R04] Manual variant follows boost request bit of the AB latch directly.
// [R05] Timed variant clears boost request itself after the timeout expires.
// [R06] Timeout code sits in function latch bits 14 down to 11.
// [R07] Timeout counter runs only when the timed-exit variant is selected.
// [R08] New AB word with boost set: secondary code, then primary, bit cleared.
// [R09] Function latch holds primary (lower) and secondary (upper) codes.
// [R10] Host keeps prescaler output at or below 300 MHz via divider ratio.
// [R11] Pump three-state bit 1 floats the pump output, 0 enables it.
// [R12] One function latch bit sets phase detector polarity.
// [R13] Select 11 loads the initialization latch with function fields.
// [R14] Initialization load pulses internal reset of counters and pump.
// [R15] Only the first AB load after initialization repeats the pulse.
// [R16] Synchronous power-down programmed and enable high: pulse triggers it.
// [R17] Host power-up order: init, function, reference, AB, hold bit 0.
// [R18] Enable pin low powers down at once; high resumes counting.
// [R19] Latch contents survive enable pin toggles.
// [R20] Three-bit function latch field steers the monitor output.
// [R21] 24 bits shift on rising serial clock; strobe rise loads latch.
// [R22] Counter hold bit 2 holds reference and AB counters in reset.
// [R23] Timer counts detector cycles to a table value, restarts on request.
`timescale 1ns/1ns

module sfl_ctrl
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial write port and chip enable pins
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic latch_strobe,
   input wire logic chip_enable,
   // Phase detector cycle marker from the analog core
   input wire logic pd_cycle,
   // Control towards the analog core
   output logic [2:0] pump_current,
   output logic pump_output_oe,
   output logic pd_polarity,
   output logic [1:0] divider_ratio,
   output logic counter_reset,
   output logic power_down,
   output logic internal_reset,
   output logic [23:0] ref_word,
   output logic [23:0] ab_word,
   output logic monitor_output_pin
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Stage 0 is read only by stage 1; edges are found between 1 and 2.
   logic [3:0] sync0_q;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] pins;

   assign pins = {pd_cycle, chip_enable, latch_strobe, ser_clk};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync0_q <= 4'h0;
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync0_q <= pins;
         sync1_q <= sync0_q;
         sync2_q <= sync1_q;
      end
   end

   logic data0_q;
   logic data1_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data0_q <= 1'b0;
         data1_q <= 1'b0;
      end
      else
      begin
         data0_q <= ser_data;
         data1_q <= data0_q;
      end
   end

   logic sclk_rise;
   logic strobe_rise;
   logic ce_level;
   logic pd_tick;

   assign sclk_rise = sync1_q[0] & ~sync2_q[0];
   assign strobe_rise = sync1_q[1] & ~sync2_q[1];
   assign ce_level = sync1_q[2];
   assign pd_tick = sync1_q[3] & ~sync2_q[3];

   // ------------------------------------------------------------------
   // Serial input register
   // ------------------------------------------------------------------
   logic [23:0] shift_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         shift_q <= 24'h00_0000;
      else if (sclk_rise)
         shift_q <= {shift_q[22:0], data1_q}; // [R21]
   end

   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   logic ahb_take;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;

   assign ahb_take = hsel & htrans[1] & hready;

   // The slave never inserts wait states and always answers OKAY.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend_q <= ahb_take & hwrite;
         if (ahb_take)
            wr_addr_q <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Software load of a whole 24-bit word acts like a serial strobe.
   // A serial strobe in the same cycle wins; the bus word is dropped.
   logic load_go;
   logic [23:0] load_word;

   always_comb
   begin
      load_go = 1'b0;
      load_word = shift_q;
      if (strobe_rise)
         load_go = 1'b1; // [R21]
      else if (wr_pend_q && wr_addr_q == sfl_pkg::ADDR_LOAD)
      begin
         load_go = 1'b1;
         load_word = hwdata[23:0];
      end
   end

   // ------------------------------------------------------------------
   // Latches
   // ------------------------------------------------------------------
   sfl_pkg::sfl_func_type func_q;
   sfl_pkg::sfl_ab_type ab_q;
   logic [23:0] ref_q;
   logic load_func;
   logic load_init;
   logic load_ab;
   logic timer_expire;

   assign load_func = load_go && load_word[1:0] == sfl_pkg::SEL_FUNC;
   assign load_init = load_go && load_word[1:0] == sfl_pkg::SEL_INIT;
   assign load_ab = load_go && load_word[1:0] == sfl_pkg::SEL_AB;

   // Latches are never cleared by the enable pin, only by hresetn and, for the AB boost bit, by the timer.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         func_q <= sfl_pkg::FUNC_RESET;
      else if (load_func || load_init)
         func_q <= load_word; // [R13] [R19]
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ref_q <= sfl_pkg::REF_RESET;
      else if (load_go && load_word[1:0] == sfl_pkg::SEL_REF)
         ref_q <= load_word; // [R19]
   end

   // A new AB word wins over the timer's clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ab_q <= sfl_pkg::AB_RESET;
      else if (load_ab)
         ab_q <= load_word; // [R04] [R08]
      else if (timer_expire)
         ab_q.boost_request <= 1'b0; // [R05] [R08]
   end

   // ------------------------------------------------------------------
   // Internal reset pulse
   // ------------------------------------------------------------------
   logic armed_q;
   logic pulse_d;

   assign pulse_d = load_init | (load_ab & armed_q); // [R14] [R15]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         armed_q <= 1'b0;
      else if (load_init)
         armed_q <= 1'b1; // [R15]
      else if (load_ab)
         armed_q <= 1'b0; // [R15]
   end

   // ------------------------------------------------------------------
   // Power-down
   // ------------------------------------------------------------------
   // Synchronous power-down waits for a pump event so that the loop does
   // not see a partial correction pulse.
   logic sync_pd_q;
   logic sync_req;
   logic pd_now;
   sfl_pkg::sfl_func_type load_fn;

   assign load_fn = load_word;
   assign sync_req = func_q.power_down_request & func_q.power_down_sync_select;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sync_pd_q <= 1'b0;
      else if (load_init)
         sync_pd_q <= ce_level & load_fn.power_down_request
            & load_fn.power_down_sync_select; // [R16]
      else if (!sync_req)
         sync_pd_q <= 1'b0;
      else if (pd_tick || (pulse_d && ce_level))
         sync_pd_q <= 1'b1; // [R16]
   end

   assign pd_now = ~ce_level // [R18]
      | (func_q.power_down_request & ~func_q.power_down_sync_select)
      | sync_pd_q;

   // ------------------------------------------------------------------
   // Fastlock timeout counter
   // ------------------------------------------------------------------
   logic timed_mode;
   logic [7:0] timer_q;
   logic timer_run;
   logic hold_now;

   assign timed_mode = func_q.fastlock_enable & func_q.fastlock_mode; // [R07]
   assign timer_run = timed_mode & ab_q.boost_request;
   assign hold_now = func_q.counter_hold | pd_now | pulse_d;
   assign timer_expire = timer_run & pd_tick
      & (timer_q == sfl_pkg::TIMEOUT_TABLE[func_q.timeout_code]); // [R06]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         timer_q <= sfl_pkg::TIMER_RESET;
      else if (load_ab || !timer_run || pd_now || pulse_d)
         timer_q <= sfl_pkg::TIMER_RESET; // [R23] [R14]
      else if (pd_tick)
         timer_q <= timer_q + 8'h01; // [R23]
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   logic fast_active;

   // Manual variant just follows the bit; timed variant relies on the
   // timer clearing it.
   assign fast_active = func_q.fastlock_enable & ab_q.boost_request; // [R01]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pump_current <= 3'h0;
         pump_output_oe <= 1'b0;
         pd_polarity <= 1'b0;
         divider_ratio <= 2'h0;
         counter_reset <= 1'b1;
         power_down <= 1'b1;
         internal_reset <= 1'b0;
         ref_word <= sfl_pkg::REF_RESET;
         ab_word <= sfl_pkg::AB_RESET;
      end
      else
      begin
         pump_current <= fast_active ? func_q.pump_current_secondary
            : func_q.pump_current_primary; // [R03] [R09] [R02]
         pump_output_oe <= ~(func_q.pump_tristate | hold_now); // [R11] [R14]
         pd_polarity <= func_q.pd_polarity; // [R12]
         divider_ratio <= func_q.divider_ratio;
         counter_reset <= hold_now; // [R22] [R14]
         power_down <= pd_now; // [R18]
         internal_reset <= pulse_d; // [R14]
         ref_word <= ref_q;
         ab_word <= ab_q;
      end
   end

   // Monitor output choice.
   logic mon_d;

   always_comb
   begin
      case (sfl_pkg::sfl_mon_type'(func_q.monitor_sel)) // [R20]
         sfl_pkg::MON_LOW: mon_d = 1'b0;
         sfl_pkg::MON_FASTLOCK: mon_d = fast_active;
         sfl_pkg::MON_TIMER: mon_d = timer_run;
         sfl_pkg::MON_RESET_PULSE: mon_d = pulse_d;
         sfl_pkg::MON_POWER_DOWN: mon_d = pd_now;
         sfl_pkg::MON_SERIAL_DATA: mon_d = data1_q;
         sfl_pkg::MON_COUNTER_RESET: mon_d = hold_now;
         sfl_pkg::MON_HIGH: mon_d = 1'b1;
         default: mon_d = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         monitor_output_pin <= 1'b0;
      else
         monitor_output_pin <= mon_d;
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   logic [31:0] status;
   logic [31:0] rd_d;

   always_comb
   begin
      status = 32'h0000_0000;
      status[sfl_pkg::ST_FASTLOCK] = fast_active;
      status[sfl_pkg::ST_TIMER_RUN] = timer_run;
      status[sfl_pkg::ST_POWER_DOWN] = pd_now;
      status[sfl_pkg::ST_INIT_ARMED] = armed_q;
      status[sfl_pkg::ST_COUNTER_RESET] = hold_now;
      status[sfl_pkg::ST_TIMER_LSB +: 8] = timer_q;
   end

   always_comb
   begin
      case (haddr[7:0])
         sfl_pkg::ADDR_FUNC: rd_d = {8'h00, func_q};
         sfl_pkg::ADDR_REF: rd_d = {8'h00, ref_q};
         sfl_pkg::ADDR_AB: rd_d = {8'h00, ab_q};
         sfl_pkg::ADDR_STATUS: rd_d = status;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ahb_take && !hwrite)
         hrdata <= rd_d;
   end

endmodule

// ===== verilog/sfl_pkg.sv
// Package of the synthesizer fastlock and initialization control block.
// Assumes a single 10 MHz bus clock and 24-bit serial latch words.
package sfl_pkg;

   // ------------------------------------------------------------------
   // Serial word layout
   // ------------------------------------------------------------------
   localparam int WORD_BITS = 24;
   localparam logic [1:0] SEL_REF = 2'b00;
   localparam logic [1:0] SEL_AB = 2'b01;
   localparam logic [1:0] SEL_FUNC = 2'b10;
   localparam logic [1:0] SEL_INIT = 2'b11;

   // Function and initialization latch, most significant field first.
   typedef struct packed {
      logic [1:0] divider_ratio;
      logic power_down_sync_select;
      logic [2:0] pump_current_secondary;
      logic [2:0] pump_current_primary;
      logic [3:0] timeout_code;
      logic fastlock_mode;
      logic fastlock_enable;
      logic pump_tristate;
      logic pd_polarity;
      logic [2:0] monitor_sel;
      logic power_down_request;
      logic counter_hold;
      logic [1:0] latch_select;
   } sfl_func_type;

   // AB counter latch.
   typedef struct packed {
      logic [1:0] spare;
      logic boost_request;
      logic [12:0] b_count;
      logic [5:0] a_count;
      logic [1:0] latch_select;
   } sfl_ab_type;

   localparam logic [23:0] FUNC_RESET = 24'h00_0000;
   localparam logic [23:0] AB_RESET = 24'h00_0000;
   localparam logic [23:0] REF_RESET = 24'h00_0000;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_FUNC = 8'h00;
   localparam logic [7:0] ADDR_REF = 8'h04;
   localparam logic [7:0] ADDR_AB = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_LOAD = 8'h10;

   // Status register bit positions.
   localparam int ST_FASTLOCK = 0;
   localparam int ST_TIMER_RUN = 1;
   localparam int ST_POWER_DOWN = 2;
   localparam int ST_INIT_ARMED = 3;
   localparam int ST_COUNTER_RESET = 4;
   localparam int ST_TIMER_LSB = 8;

   // Timeout lengths minus one, in phase detector cycles, indexed by timeout_code.
   localparam logic [7:0] TIMEOUT_TABLE [16] = '{
      8'h03, 8'h07, 8'h0B, 8'h0F, 8'h13, 8'h17, 8'h1B, 8'h1F,
      8'h23, 8'h27, 8'h2B, 8'h2F, 8'h33, 8'h37, 8'h3B, 8'h3F};
   localparam logic [7:0] TIMER_RESET = 8'h00;

   typedef enum logic [2:0] {
      MON_LOW, MON_FASTLOCK, MON_TIMER, MON_RESET_PULSE,
      MON_POWER_DOWN, MON_SERIAL_DATA, MON_COUNTER_RESET, MON_HIGH
   } sfl_mon_type;

endpackage
